// [hdl/min_tracker_params.svh]
// constants for the per-channel minimum code register bank
`ifndef MIN_TRACKER_PARAMS_SVH
`define MIN_TRACKER_PARAMS_SVH

// ----------------------------------------------------------------------
// register offsets, low byte even, high byte next odd
// ----------------------------------------------------------------------
`define MT_MIN_BASE        8'h80
`define MT_CH0_LOW         8'h80
`define MT_CH0_HIGH        8'h81
`define MT_CH1_LOW         8'h82
`define MT_CH1_HIGH        8'h83
`define MT_CH2_LOW         8'h84
`define MT_CH2_HIGH        8'h85
`define MT_CH3_LOW         8'h86
`define MT_CH3_HIGH        8'h87

// ----------------------------------------------------------------------
// field layout and values
// ----------------------------------------------------------------------
`define MT_FIELD_MSB       7
`define MT_FIELD_LSB       0
`define MT_REARM_BYTE      8'hff
`define MT_RESET_BYTE      8'hff
`define MT_UNMAPPED_DATA   8'h00
`define MT_NUM_CH          4
`define MT_ADDR_W          8
`define MT_CHAN_W          3
`define MT_CODE_W          16

`endif

// [hdl/min_tracker_pkg.sv]
// types shared by the minimum code register bank
`include "min_tracker_params.svh"

package min_tracker_pkg;

    // one conversion result from the converter path
    typedef struct packed {
        logic                      valid;
        logic [`MT_CHAN_W-1:0]     channel;
        logic [`MT_CODE_W-1:0]     code;
    } conv_t;

    // register port request, rd and wr are single-cycle strobes
    typedef struct packed {
        logic                      rd;
        logic                      wr;
        logic [`MT_ADDR_W-1:0]     addr;
        logic [7:0]                wdata;
    } reg_req_t;

    // register port answer, registered
    typedef struct packed {
        logic                      valid;
        logic                      hit;
        logic                      wr_ignored;
        logic [7:0]                data;
    } reg_rsp_t;

    // state of one tracking cell
    typedef struct packed {
        logic [`MT_CODE_W-1:0]     lowest;
    } cell_state_t;

    // state of the bank front end
    typedef struct packed {
        reg_rsp_t                  rsp;
    } bank_state_t;

endpackage

// [hdl/min_code_cell.sv]
// one channel's lowest-code tracker with per-byte re-arm
`timescale 1ns/1ps
`include "min_tracker_params.svh"

module min_code_cell (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      sample,
    input  wire logic [`MT_CODE_W-1:0]     code,
    input  wire logic                      rearm_low,
    input  wire logic                      rearm_high,
    output logic      [`MT_CODE_W-1:0]     lowest
);

    min_tracker_pkg::cell_state_t state;
    min_tracker_pkg::cell_state_t next_state;
    logic [`MT_CODE_W-1:0]        armed;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    // re-arm first, then compare, so a code landing with a read
    // is measured against the fresh all-ones byte and is not lost
    always_comb begin
        next_state = state;
        armed      = state.lowest;
        if (rearm_low) begin
            armed[7:0] = `MT_REARM_BYTE;             // [R2]
        end
        if (rearm_high) begin
            armed[15:8] = `MT_REARM_BYTE;            // [R2]
        end
        next_state.lowest = armed;
        if (sample && (code < armed)) begin
            next_state.lowest = code;                // [R1] [R5] [R7]
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    // both bytes come out of reset as all ones
    always_ff @(posedge clk) begin
        if (rst) begin
            state.lowest <= {`MT_RESET_BYTE, `MT_RESET_BYTE}; // [R3] [R6]
        end else begin
            state <= next_state;
        end
    end

    assign lowest = state.lowest;

endmodule // min_code_cell

// [hdl/channel_minimum_code_tracker.sv]
// read-clear register bank of lowest conversion codes per channel
`timescale 1ns/1ps
`include "min_tracker_params.svh"

// Function
// R1: each channel keeps its smallest code since last read, as 8-bit fields.
// R2: reading a minimum byte returns it, then sets that byte to 0xFF.
// R3: reset value 0xFF, read-only, writes ignored; ch0 high byte at 0x81.
// R4: low byte at even address, high byte at next odd address.
// R5: tracking covers every conversion of the channel since the last read.
// R6: ch0 low byte at 0x80, reset 0xFF, starts the range.
// R7: smaller code replaces minimum same cycle; coinciding read re-arms first.
module channel_minimum_code_tracker #(
    parameter int NUM_CH = `MT_NUM_CH
) (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire min_tracker_pkg::conv_t        conv,
    input  wire min_tracker_pkg::reg_req_t     req,
    output min_tracker_pkg::reg_rsp_t          rsp,
    output logic [NUM_CH-1:0][`MT_CODE_W-1:0]  lowest_codes
);

    // ------------------------------------------------------------------
    // address decode helpers
    // ------------------------------------------------------------------

    // offset of an address inside the bank, wraps for addresses below it
    function automatic logic [`MT_ADDR_W-1:0] bank_index(
        input logic [`MT_ADDR_W-1:0] addr
    );
        bank_index = addr - `MT_MIN_BASE;
    endfunction

    // true when the address falls on one of the tracked bytes
    function automatic logic bank_hit(
        input logic [`MT_ADDR_W-1:0] addr
    );
        logic [`MT_ADDR_W-1:0] idx;
        idx      = bank_index(addr);
        bank_hit = (addr >= `MT_MIN_BASE)
                && (idx < `MT_ADDR_W'(2 * NUM_CH));  // [R4] [R6]
    endfunction

    // channel number from an address, two bytes per channel
    function automatic logic [`MT_ADDR_W-1:0] bank_chan(
        input logic [`MT_ADDR_W-1:0] addr
    );
        bank_chan = bank_index(addr) >> 1;           // [R4]
    endfunction

    // odd offset selects the high byte
    function automatic logic bank_upper(
        input logic [`MT_ADDR_W-1:0] addr
    );
        logic [`MT_ADDR_W-1:0] idx;
        idx        = bank_index(addr);
        bank_upper = idx[0];                         // [R4]
    endfunction

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    min_tracker_pkg::bank_state_t   state;
    min_tracker_pkg::bank_state_t   next_state;
    logic                           rd_hit;
    logic                           rd_upper;
    logic [`MT_ADDR_W-1:0]          rd_chan;
    logic [NUM_CH-1:0]              rearm_low;
    logic [NUM_CH-1:0]              rearm_high;
    logic [NUM_CH-1:0]              sample;
    logic [NUM_CH-1:0][`MT_CODE_W-1:0] cell_lowest;

    // ------------------------------------------------------------------
    // read decode
    // ------------------------------------------------------------------
    // a read strobe on a tracked byte re-arms exactly that byte
    always_comb begin
        rd_hit   = req.rd && bank_hit(req.addr);
        rd_upper = bank_upper(req.addr);
        rd_chan  = bank_chan(req.addr);
    end

    // ------------------------------------------------------------------
    // per-channel strobes
    // ------------------------------------------------------------------
    // codes for channels beyond this bank are simply not tracked here;
    // writes never reach the cells, so content is read-only
    always_comb begin
        for (int ch = 0; ch < NUM_CH; ch++) begin
            sample[ch]     = conv.valid
                          && (conv.channel == `MT_CHAN_W'(ch)); // [R5]
            rearm_low[ch]  = rd_hit && !rd_upper
                          && (rd_chan == `MT_ADDR_W'(ch));      // [R2]
            rearm_high[ch] = rd_hit && rd_upper
                          && (rd_chan == `MT_ADDR_W'(ch));      // [R2]
        end
    end

    // ------------------------------------------------------------------
    // tracking cells
    // ------------------------------------------------------------------
    // one cell per channel; each holds its own 16-bit minimum so the
    // compare always uses the full code, not a single byte
    for (genvar g = 0; g < NUM_CH; g++) begin : g_cell
        min_code_cell u_cell (
            .clk        (clk),
            .rst        (rst),
            .sample     (sample[g]),
            .code       (conv.code),
            .rearm_low  (rearm_low[g]),
            .rearm_high (rearm_high[g]),
            .lowest     (cell_lowest[g])
        );
    end

    // ------------------------------------------------------------------
    // answer next state
    // ------------------------------------------------------------------
    // read data is taken from the cell before this edge, so the host sees
    // the old minimum while the cell re-arms in the same cycle
    always_comb begin
        next_state                = state;
        next_state.rsp.valid      = req.rd;
        next_state.rsp.hit        = rd_hit;
        next_state.rsp.wr_ignored = req.wr && bank_hit(req.addr); // [R3]
        next_state.rsp.data       = `MT_UNMAPPED_DATA;
        if (!req.rd) begin
            next_state.rsp.data = state.rsp.data;    // hold last answer
        end else if (rd_hit) begin
            for (int ch = 0; ch < NUM_CH; ch++) begin
                if (rd_chan == `MT_ADDR_W'(ch)) begin
                    if (rd_upper) begin
                        next_state.rsp.data =
                            cell_lowest[ch][15:8];   // [R1] [R2]
                    end else begin
                        next_state.rsp.data =
                            cell_lowest[ch][7:0];    // [R1] [R2]
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // answer register
    // ------------------------------------------------------------------
    // answer data after reset shows the unmapped value, not a cell byte
    always_ff @(posedge clk) begin
        if (rst) begin
            state.rsp.valid      <= 1'b0;
            state.rsp.hit        <= 1'b0;
            state.rsp.wr_ignored <= 1'b0;
            state.rsp.data       <= `MT_UNMAPPED_DATA;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // live minima feed downstream comparators; all come from flip-flops
    assign rsp          = state.rsp;
    assign lowest_codes = cell_lowest;              // [R1]

endmodule // channel_minimum_code_tracker

// [testbench/channel_minimum_code_tracker_assertions.sv]
// port-level checks on the minimum code register bank
`timescale 1ns/1ps
`include "min_tracker_params.svh"
module min_tracker_checker #(
    parameter int NUM_CH = 4
) (
    input wire logic                              clk,
    input wire logic                              rst,
    input wire min_tracker_pkg::conv_t            conv,
    input wire min_tracker_pkg::reg_req_t         req,
    input wire min_tracker_pkg::reg_rsp_t         rsp,
    input wire logic [NUM_CH-1:0][`MT_CODE_W-1:0] lowest_codes
);
    // ------------------------------------------------------------------
    // register port and tracking cells
    // ------------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic map;
    assign map = req.addr[7:3] == 5'h10; // 0x80..0x87 only
    // a coinciding code would mask the re-arm, so leave it out
    sequence s_rd_c0h;
        req.rd && req.addr == 8'h81 && !(conv.valid && conv.channel == 3'h0);
    endsequence
    sequence s_rearmed;
        rsp.data == $past(lowest_codes[0][15:8]) &&
            lowest_codes[0][15:8] == 8'hff;
    endsequence
    property p_ans; req.rd |=> rsp.valid; endproperty
    property p_quiet; !req.rd |=> !rsp.valid; endproperty
    property p_hit; req.rd && map |=> rsp.hit; endproperty
    property p_miss; req.rd && !map |=> !rsp.hit && rsp.data == 8'h00;
    endproperty
    property p_wr; req.wr && map |=> rsp.wr_ignored; endproperty
    property p_rearm; s_rd_c0h |=> s_rearmed; endproperty
    property p_upd;
        conv.valid && conv.channel == 3'h2 && !req.rd &&
            conv.code < lowest_codes[2] |=>
            lowest_codes[2] == $past(conv.code);
    endproperty
    property p_hold; !conv.valid && !req.rd |=> $stable(lowest_codes);
    endproperty
    a_ans:   assert property (p_ans) else $error("read not answered");
    a_quiet: assert property (p_quiet) else $error("stray answer");
    a_hit:   assert property (p_hit) else $error("mapped miss");
    a_miss:  assert property (p_miss) else $error("unmapped hit");
    a_wr:    assert property (p_wr) else $error("write not flagged");
    a_rearm: assert property (p_rearm) else $error("no re-arm");
    a_upd:   assert property (p_upd) else $error("min not taken");
    a_hold:  assert property (p_hold) else $error("min drifted");
endmodule // min_tracker_checker

bind channel_minimum_code_tracker
    min_tracker_checker #(.NUM_CH(NUM_CH)) u_chk (
        .clk(clk), .rst(rst), .conv(conv), .req(req), .rsp(rsp),
        .lowest_codes(lowest_codes));

// [testbench/tb.sv]
// self-checking bench for the minimum code register bank
`timescale 1ns/1ps
`include "min_tracker_params.svh"
module tb;
    localparam int NUM_CH = 4;
    logic                              clk;
    logic                              rst;
    min_tracker_pkg::conv_t            conv;
    min_tracker_pkg::reg_req_t         req;
    min_tracker_pkg::reg_rsp_t         rsp;
    logic [NUM_CH-1:0][`MT_CODE_W-1:0] lowest_codes;
    int                                err_total;
    int                                checks_done;

    channel_minimum_code_tracker #(.NUM_CH(NUM_CH)) dut (
        .clk(clk), .rst(rst), .conv(conv), .req(req), .rsp(rsp),
        .lowest_codes(lowest_codes));

    // ------------------------------------------------------------------
    // clock, shared drivers and compare
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string what, input logic [15:0] e,
                       input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask
    // answer is registered, so it is judged one edge after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk); #1;
        req.rd = 1'b1;
        req.addr = a;
        @(posedge clk); #1;
        req.rd = 1'b0;
        chk("rsp.valid", 16'h1, {15'h0, rsp.valid});
        chk("rsp.hit", {15'h0, a[7:3] == 5'h10}, {15'h0, rsp.hit});
        chk("rsp.data", {8'h0, e}, {8'h0, rsp.data});
    endtask
    task automatic cv(input logic [2:0] ch, input logic [15:0] c);
        @(posedge clk); #1;
        conv = '{1'b1, ch, c};
        @(posedge clk); #1;
        conv.valid = 1'b0;
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        for (int a = 8'h80; a < 8'h88; a++) begin
            rd(a[7:0], 8'hff);
        end
        rd(8'h88, 8'h00);
        chk("lowest ch3", 16'hffff, lowest_codes[3]);
        $display("test reset done");
    endtask
    // per channel: keep the smallest, ignore larger and foreign codes
    task automatic t_track();
        logic [15:0] m;
        for (int c = 0; c < NUM_CH; c++) begin
            m = 16'h3a5c - 16'(16'h0101 * c);
            cv(c[2:0], 16'h7000);
            cv(c[2:0], m);
            cv(c[2:0], m + 16'h1);
            cv(3'h5, 16'h0000);
            chk("lowest", m, lowest_codes[c]);
            rd(8'h80 + 8'(2 * c), m[7:0]);
            rd(8'h80 + 8'(2 * c), 8'hff);
            rd(8'h81 + 8'(2 * c), m[15:8]);
            chk("re-armed", 16'hffff, lowest_codes[c]);
        end
        $display("test track done");
    endtask
    task automatic t_write();
        cv(3'h1, 16'h0042);
        @(posedge clk); #1;
        req.wr = 1'b1;
        req.addr = 8'h82;
        req.wdata = 8'h99;
        @(posedge clk); #1;
        req.wr = 1'b0;
        chk("wr_ignored", 16'h1, {15'h0, rsp.wr_ignored});
        rd(8'h82, 8'h42);
        rd(8'h83, 8'h00);
        $display("test write done");
    endtask
    // re-arm of the low byte lands first, so 0x0380 must win; the old
    // low byte is non-zero so it cannot pass as unmapped data
    task automatic t_both();
        cv(3'h2, 16'h0312);
        @(posedge clk); #1;
        req.rd = 1'b1;
        req.addr = 8'h84;
        conv = '{1'b1, 3'h2, 16'h0380};
        @(posedge clk); #1;
        req.rd = 1'b0;
        conv.valid = 1'b0;
        chk("rsp.hit", 16'h1, {15'h0, rsp.hit});
        chk("rsp.data", 16'h0012, {8'h0, rsp.data});
        chk("lowest ch2", 16'h0380, lowest_codes[2]);
        $display("test coincide done");
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        complete_run();
    end
    initial begin
        err_total = 0;
        checks_done = 0;
        rst = 1'b1;
        conv = '0;
        req = '0;
        repeat (20) @(posedge clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_track();
        t_write();
        t_both();
        complete_run();
    end
endmodule // tb
